// *** rtl/entry_mem.sv ***
`timescale 1ns/1ns
module entry_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  logic          core_clk,
  input  logic          rst,
  input  logic          ce,
  input  logic          wr_en,
  input  logic [AW-1:0] wr_addr,
  input  logic [W-1:0]  wr_data,
  input  logic [AW-1:0] rd_a_addr,
  output logic [W-1:0]  rd_a_data,
  input  logic [AW-1:0] rd_b_addr,
  output logic [W-1:0]  rd_b_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else if (ce) begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule

// *** rtl/multi_speed_sequencer.sv ***
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module multi_speed_sequencer
  import msseq_pkg::*;
#(
  parameter int ADDR_W     = 8,
  parameter int SEC_CYCLES = CYCLES_PER_SEC,
  parameter int REF_W      = 16,
  parameter int TIME_W     = 16,
  parameter int GRP_W      = 2,
  parameter int ENTRIES    = 16
) (
  input  logic              core_clk,
  input  logic              rst,
  input  logic              ce,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  input  logic              servo_enable,
  input  logic              direction_invert_function,
  input  logic              speed_select_bit0,
  input  logic              speed_select_bit1,
  input  logic              speed_select_bit2,
  input  logic              speed_select_bit3,
  input  logic [REF_W-1:0]  speed_feedback,
  output logic [REF_W-1:0]  speed_reference,
  output logic [GRP_W-1:0]  accel_group,
  output logic [3:0]        speed_index,
  output logic              motor_run,
  output logic              speed_reach,
  output logic              stop_request,
  output logic [1:0]        stop_mode,
  output logic              irq
);

  localparam int IDX_W = $clog2(ENTRIES);
  localparam int RG_W  = REF_W + GRP_W;

  function automatic logic [4:0] count_eff(input logic [15:0] c);
    if (c < 16'(COUNT_MIN)) return COUNT_MIN;
    if (c > 16'(COUNT_MAX)) return COUNT_MAX;
    return c[4:0];
  endfunction

  function automatic logic [IDX_W-1:0] step_index(input logic [IDX_W-1:0] idx,
                                                  input logic last);
    return last ? '0 : IDX_W'(idx + 1'b1);
  endfunction

  function automatic logic reached(input logic [REF_W-1:0] fb, input logic [REF_W-1:0] rf);
    return rf[REF_W-1] ? ($signed(fb) <= $signed(rf)) : ($signed(fb) >= $signed(rf));
  endfunction

  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  logic              aw_full_reg, w_full_reg, ar_pend_reg;
  logic [ADDR_W-1:0] awaddr_hold_reg, araddr_hold_reg;
  logic [31:0]       wdata_hold_reg;
  logic [3:0]        wstrb_hold_reg;
  logic [15:0]       mode_reg, count_reg, unit_reg;
  logic [IRQ_W-1:0]  irq_stat_reg, irq_mask_reg, irq_set, irq_stat_next;
  logic [RG_W-1:0]   rg_a_data, rg_b_data;
  logic [TIME_W-1:0] tm_a_data, tm_b_data;
  logic [31:0]       rd_word;
  logic              rd_hit;

  wire [ADDR_W-1:0] wa       = {awaddr_hold_reg[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra       = {araddr_hold_reg[ADDR_W-1:2], 2'b00};
  wire              wr_fire  = aw_full_reg && w_full_reg && !bvalid;
  wire              w_mode   = wa == ADDR_W'(OFS_MODE);
  wire              w_count  = wa == ADDR_W'(OFS_COUNT);
  wire              w_unit   = wa == ADDR_W'(OFS_UNIT);
  wire              w_stop   = wa == ADDR_W'(OFS_STOP);
  wire              w_istat  = wa == ADDR_W'(OFS_IRQ_STAT);
  wire              w_imask  = wa == ADDR_W'(OFS_IRQ_MASK);
  wire              w_ref    = wa[ADDR_W-1:6] == (ADDR_W-6)'(WIN_REF);
  wire              w_time   = wa[ADDR_W-1:6] == (ADDR_W-6)'(WIN_TIME);
  wire              w_hit    = w_mode | w_count | w_unit | w_stop | w_istat | w_imask |
                               w_ref | w_time;
  wire              ent_full = wstrb_hold_reg == 4'hf;
  wire [IDX_W-1:0]  w_idx    = wa[IDX_W+1:2];
  wire [31:0]       status_word;
  wire [IRQ_W-1:0]  irq_clr  = (wr_fire && w_istat) ? wdata_hold_reg[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;  wready <= 1'b1;  aw_full_reg <= 1'b0;  w_full_reg <= 1'b0;
      awaddr_hold_reg <= '0;  wdata_hold_reg <= '0;  wstrb_hold_reg <= '0;
      bvalid <= 1'b0;  bresp <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_full_reg     <= 1'b1;
        awready         <= 1'b0;
        awaddr_hold_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_reg     <= 1'b1;
        wready         <= 1'b0;
        wdata_hold_reg <= wdata;
        wstrb_hold_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= RST_MODE;  count_reg <= RST_COUNT;  unit_reg <= RST_UNIT;
      stop_mode <= RST_STOP;  irq_mask_reg <= '0;
    end else if (ce && wr_fire) begin
      if (w_mode)  mode_reg     <= lanes(mode_reg, wdata_hold_reg, wstrb_hold_reg);
      if (w_count) count_reg    <= lanes(count_reg, wdata_hold_reg, wstrb_hold_reg);
      if (w_unit)  unit_reg     <= lanes(unit_reg, wdata_hold_reg, wstrb_hold_reg);
      if (w_stop && wstrb_hold_reg[0]) stop_mode <= wdata_hold_reg[1:0];
      if (w_imask && wstrb_hold_reg[0]) irq_mask_reg <= wdata_hold_reg[IRQ_W-1:0];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (ra == ADDR_W'(OFS_MODE)) rd_word = {16'h0000, mode_reg};
    else if (ra == ADDR_W'(OFS_COUNT)) rd_word = {16'h0000, count_reg};
    else if (ra == ADDR_W'(OFS_UNIT)) rd_word = {16'h0000, unit_reg};
    else if (ra == ADDR_W'(OFS_STOP)) rd_word = {30'h0, stop_mode};
    else if (ra == ADDR_W'(OFS_STATUS)) rd_word = status_word;
    else if (ra == ADDR_W'(OFS_IRQ_STAT)) rd_word = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
    else if (ra == ADDR_W'(OFS_IRQ_MASK)) rd_word = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
    else if (ra[ADDR_W-1:6] == (ADDR_W-6)'(WIN_REF)) rd_word = {{(32-RG_W){1'b0}}, rg_b_data};
    else if (ra[ADDR_W-1:6] == (ADDR_W-6)'(WIN_TIME)) rd_word = {{(32-TIME_W){1'b0}}, tm_b_data};
    else rd_hit = 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;  ar_pend_reg <= 1'b0;  araddr_hold_reg <= '0;
      rvalid <= 1'b0;  rdata <= 32'h0000_0000;  rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready         <= 1'b0;
        ar_pend_reg     <= 1'b1;
        araddr_hold_reg <= araddr;
      end
      if (ar_pend_reg) begin
        ar_pend_reg <= 1'b0;
        rvalid      <= 1'b1;
        rdata       <= rd_word;
        rresp       <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed entries

  seq_state_t        state_reg, state_next;
  logic [IDX_W-1:0]  index_reg, index_next;
  logic [TIME_W-1:0] elapsed_reg, elapsed_next, cur_time_reg;
  logic [REF_W-1:0]  cur_ref_reg;
  logic              servo_d_reg, unit_tick;

  entry_mem #(.W(RG_W), .DEPTH(ENTRIES), .AW(IDX_W)) u_ref_mem (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (wr_fire && w_ref && ent_full),
    .wr_addr   (w_idx),
    .wr_data   (wdata_hold_reg[RG_W-1:0]),
    .rd_a_addr (index_reg),
    .rd_a_data (rg_a_data),
    .rd_b_addr (araddr[IDX_W+1:2]),
    .rd_b_data (rg_b_data)
  );

  entry_mem #(.W(TIME_W), .DEPTH(ENTRIES), .AW(IDX_W)) u_time_mem (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (wr_fire && w_time && ent_full),
    .wr_addr   (w_idx),
    .wr_data   (wdata_hold_reg[TIME_W-1:0]),
    .rd_a_addr (index_reg),
    .rd_a_data (tm_a_data),
    .rd_b_addr (araddr[IDX_W+1:2]),
    .rd_b_data (tm_b_data)
  );

  unit_tick_gen #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clear    (state_reg != ST_RUN),
    .unit_min (unit_reg[0]),
    .tick     (unit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  wire             m_indiv  = mode_reg == MODE_INDIV;
  wire             m_cyclic = mode_reg == MODE_CYCLIC;
  wire             m_di     = mode_reg == MODE_DI;
  wire             m_seq    = m_indiv | m_cyclic;
  wire [4:0]       cnt      = count_eff(count_reg);
  wire             last     = ({1'b0, index_reg} + 5'h01) == cnt;
  wire [IDX_W-1:0] di_sel   = {speed_select_bit3, speed_select_bit2,
                               speed_select_bit1, speed_select_bit0};
  wire             expire   = state_reg == ST_RUN && m_seq && unit_tick &&
                              TIME_W'(elapsed_reg + 1'b1) >= cur_time_reg;
  wire             servo_fall = servo_d_reg && !servo_enable;
  wire             load_go  = state_reg == ST_EVAL && state_next == ST_RUN;
  wire             run_next = servo_enable && state_next != ST_IDLE && state_next != ST_DONE;
  wire [REF_W-1:0] ref_sel  = load_go ? rg_a_data[REF_W-1:0] : cur_ref_reg;
  wire [REF_W-1:0] ref_dir  = direction_invert_function ? REF_W'(-ref_sel) : ref_sel;
  wire             reach_next = state_reg == ST_RUN && state_next == ST_RUN &&
                                reached(speed_feedback, speed_reference);

  assign status_word = {23'h0, speed_reach, motor_run, state_reg, index_reg};

  always_comb begin
    state_next   = state_reg;
    index_next   = index_reg;
    elapsed_next = elapsed_reg;
    if (!servo_enable) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (m_seq) begin
            state_next   = ST_LOAD;
            index_next   = '0;
            elapsed_next = '0;
          end else if (m_di) begin
            state_next = ST_LOAD;
            index_next = di_sel;
          end
        end
        ST_LOAD: begin
          state_next = ST_EVAL;
        end
        ST_EVAL: begin
          if (m_seq && tm_a_data == '0) begin
            state_next = (last && m_indiv) ? ST_DONE : ST_LOAD;
            index_next = step_index(index_reg, last);
          end else begin
            state_next   = ST_RUN;
            elapsed_next = '0;
          end
        end
        ST_RUN: begin
          if (expire) begin
            elapsed_next = '0;
            state_next   = (last && m_indiv) ? ST_DONE : ST_LOAD;
            index_next   = step_index(index_reg, last);
          end else if (m_di && di_sel != index_reg) begin
            state_next = ST_LOAD;
            index_next = di_sel;
          end else if (!m_seq && !m_di) begin
            state_next = ST_DONE;
          end else if (m_seq && unit_tick) begin
            elapsed_next = TIME_W'(elapsed_reg + 1'b1);
          end
        end
        ST_DONE: begin
          state_next = ST_DONE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_STEP]  = expire && state_next == ST_LOAD;
    irq_set[IRQ_DONE]  = state_next == ST_DONE && state_reg != ST_DONE;
    irq_set[IRQ_ABORT] = servo_fall && state_reg != ST_IDLE && state_reg != ST_DONE;
    irq_set[IRQ_REACH] = reach_next && !speed_reach;
    // a new event outlives a simultaneous write-one clear
    irq_stat_next      = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;  index_reg <= '0;  elapsed_reg <= '0;  servo_d_reg <= 1'b0;
      cur_time_reg <= '0;  cur_ref_reg <= '0;  accel_group <= '0;
    end else if (ce) begin
      state_reg   <= state_next;
      index_reg   <= index_next;
      elapsed_reg <= elapsed_next;
      servo_d_reg <= servo_enable;
      if (load_go) begin
        cur_time_reg <= tm_a_data;
        cur_ref_reg  <= rg_a_data[REF_W-1:0];
        accel_group  <= rg_a_data[RG_W-1:REF_W];
      end else if (state_next == ST_IDLE || state_next == ST_DONE) begin
        cur_ref_reg <= '0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      speed_reference <= '0;  speed_index <= '0;  motor_run <= 1'b0;  speed_reach <= 1'b0;
      stop_request <= 1'b0;  irq_stat_reg <= '0;  irq <= 1'b0;
    end else if (ce) begin
      speed_reference <= run_next ? ref_dir : '0;
      speed_index     <= index_next;
      motor_run       <= run_next;
      speed_reach     <= reach_next;
      stop_request    <= irq_set[IRQ_ABORT];
      irq_stat_reg    <= irq_stat_next;
      irq             <= |(irq_stat_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !ce);

  a_mode_invalid_idle: assert property (
    (state_reg == ST_IDLE && !m_seq && !m_di) |=> state_reg == ST_IDLE)
    else $error("sequencer left idle under an undefined mode");
  a_index_in_count: assert property (
    (m_seq && state_reg == ST_RUN) |-> ({1'b0, index_reg} < cnt))
    else $error("speed index beyond configured count");
  a_elapsed_bound: assert property (
    (state_reg == ST_RUN && m_seq) |-> elapsed_reg < cur_time_reg)
    else $error("elapsed time passed the entry time");
  a_dir_sign: assert property (
    (run_next && !load_go && direction_invert_function) |=> speed_reference == REF_W'(-cur_ref_reg))
    else $error("reference sign not inverted");
  a_single_pass_end: assert property (
    (expire && last && m_indiv && servo_enable) |=> state_reg == ST_DONE ##1 !motor_run)
    else $error("single pass did not stop after last speed");
  a_auto_step: assert property (
    (expire && !last && servo_enable) |=> state_reg == ST_LOAD &&
      index_reg == IDX_W'($past(index_reg) + 1'b1) ##1 state_reg == ST_EVAL)
    else $error("no automatic step on expiry");
  a_step_clears: assert property (
    (load_go && servo_enable) |=> elapsed_reg == '0 && state_reg == ST_RUN)
    else $error("time not restarted at new speed");
  a_zero_skip: assert property (
    (state_reg == ST_EVAL && m_seq && tm_a_data == '0 && servo_enable) |=> state_reg != ST_RUN)
    else $error("zero time entry was run");
  a_reach_flag: assert property (
    (state_reg == ST_RUN && state_next == ST_RUN && reached(speed_feedback, speed_reference))
      |=> speed_reach)
    else $error("speed reach missing");
  a_servo_abort: assert property (
    (servo_fall && state_reg == ST_RUN) |=> stop_request && state_reg == ST_IDLE ##1
      !stop_request && !motor_run)
    else $error("servo off did not abort");
  a_cyclic_wrap: assert property (
    (expire && last && m_cyclic && servo_enable) |=> index_reg == '0 && state_reg == ST_LOAD)
    else $error("cyclic sequence did not wrap");
  a_di_select: assert property (
    (state_reg == ST_RUN && m_di && servo_enable && !expire && di_sel != index_reg)
      |=> index_reg == $past(di_sel) ##2 state_reg == ST_RUN)
    else $error("input selected speed not taken");
  a_restart_first: assert property (
    (state_reg == ST_IDLE && servo_enable && m_seq) |=> index_reg == '0 && elapsed_reg == '0)
    else $error("restart not at first speed");

  c_single_done: cover property (state_reg == ST_RUN ##1 state_reg == ST_DONE);
  c_cyclic_wrap: cover property (expire && last && m_cyclic);
  c_zero_skip:   cover property (state_reg == ST_EVAL && m_seq && tm_a_data == '0);
  c_abort:       cover property (stop_request);

endmodule

// *** rtl/unit_tick_gen.sv ***
`timescale 1ns/1ns
module unit_tick_gen
  import msseq_pkg::*;
#(
  parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
  input  logic core_clk,
  input  logic rst,
  input  logic ce,
  input  logic clear,
  input  logic unit_min,
  output logic tick
);

  localparam int CW = $clog2(SEC_CYCLES + 1);

  logic [CW-1:0] sec_cnt_reg;
  logic [5:0]    min_cnt_reg;
  logic          sec_wrap;
  logic          min_wrap;

  assign sec_wrap = (sec_cnt_reg == CW'(SEC_CYCLES - 1));
  assign min_wrap = (min_cnt_reg == SECS_PER_MIN - 6'h01);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sec_cnt_reg <= '0;
      min_cnt_reg <= '0;
      tick        <= 1'b0;
    end else if (ce) begin
      // phase restarts with each speed so every step gets whole units
      if (clear) begin
        sec_cnt_reg <= '0;
        min_cnt_reg <= '0;
        tick        <= 1'b0;
      end else begin
        sec_cnt_reg <= sec_wrap ? '0 : sec_cnt_reg + 1'b1;
        if (sec_wrap) begin
          min_cnt_reg <= min_wrap ? '0 : min_cnt_reg + 6'h01;
        end
        tick <= sec_wrap && (unit_min != UNIT_MIN || min_wrap);
      end
    end
  end

endmodule

// *** shared/msseq_pkg.sv ***
package msseq_pkg;

  // register byte offsets, and entry window numbers in address bits 7:6
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_COUNT     = 8'h04;
  localparam logic [7:0] OFS_UNIT      = 8'h08;
  localparam logic [7:0] OFS_STOP      = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  localparam logic [1:0] WIN_REF       = 2'h1;
  localparam logic [1:0] WIN_TIME      = 2'h2;

  // values after reset
  localparam logic [15:0] RST_MODE     = 16'h0001;
  localparam logic [15:0] RST_COUNT    = 16'h0001;
  localparam logic [15:0] RST_UNIT     = 16'h0001;
  localparam logic [1:0]  RST_STOP     = 2'h0;

  // mode and unit encodings
  localparam logic [15:0] MODE_INDIV   = 16'h0000;
  localparam logic [15:0] MODE_CYCLIC  = 16'h0001;
  localparam logic [15:0] MODE_DI      = 16'h0002;
  localparam logic        UNIT_MIN     = 1'b1;

  // entry count limits
  localparam logic [4:0]  COUNT_MIN    = 5'h01;
  localparam logic [4:0]  COUNT_MAX    = 5'h10;

  // interrupt bit positions
  localparam int IRQ_STEP  = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_REACH = 3;
  localparam int IRQ_W     = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // time base
  localparam int CLK_HZ         = 25_000_000;
  localparam int TICK_S         = 1;
  localparam int CYCLES_PER_SEC = CLK_HZ * TICK_S;
  localparam logic [5:0] SECS_PER_MIN = 6'h3c;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_EVAL = 3'b010,
    ST_RUN  = 3'b011,
    ST_DONE = 3'b100
  } seq_state_t;

endpackage

// *** verification/host_ctrl.sv ***
`timescale 1ns/1ns
module host_ctrl (
  input  wire logic       core_clk,
  input  wire logic       en_cmd,
  input  wire logic       dir_cmd,
  input  wire logic [3:0] sel_cmd,
  output logic            servo_enable,
  output logic            dir_pin,
  output logic [3:0]      sel_pin
);
  initial begin
    servo_enable = 1'b0;
    dir_pin = 1'b0;
    sel_pin = 4'h0;
  end
  // outputs move only just after an edge
  always @(posedge core_clk) begin
    servo_enable <= en_cmd;
    dir_pin <= dir_cmd;
  end
  always @(posedge core_clk) begin
    sel_pin <= sel_cmd;
  end
endmodule

// *** verification/multi_speed_sequencer_tb_top.sv ***
`timescale 1ns/1ns
module multi_speed_sequencer_tb_top;
  import msseq_pkg::*;
  logic        core_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, en = 0, dir = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd_v;
  logic [15:0] fb = 0, refs [3];
  logic [3:0]  sel = 0, s;
  logic [1:0]  rr;
  wire         awready, wready, bvalid, arready, rvalid, servo, dpin, reach, stop, run, irq;
  wire  [1:0]  bresp, rresp, grp, smode;
  wire  [31:0] rdata;
  wire  [15:0] sref;
  wire  [3:0]  idx, spin;
  int          error_cnt = 0, total_checks = 0, n;
  always #20 core_clk = ~core_clk;
  host_ctrl host (.core_clk(core_clk), .en_cmd(en), .dir_cmd(dir), .sel_cmd(sel),
    .servo_enable(servo), .dir_pin(dpin), .sel_pin(spin));
  multi_speed_sequencer #(.SEC_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .servo_enable(servo), .direction_invert_function(dpin),
    .speed_select_bit0(spin[0]), .speed_select_bit1(spin[1]), .speed_select_bit2(spin[2]),
    .speed_select_bit3(spin[3]), .speed_feedback(fb), .speed_reference(sref),
    .accel_group(grp), .speed_index(idx), .motor_run(run), .speed_reach(reach),
    .stop_request(stop), .stop_mode(smode), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo(input int k);
    if (k > 0) begin
      error_cnt++;
      finish_test();
    end
  endtask
  function logic [15:0] neg(input logic [15:0] v);
    return ~v + 16'h1;
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rr = bresp;
    bready <= 1'b0;
    tmo(int'(n == 40));
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_v = rdata;
    rr = rresp;
    rready <= 1'b0;
    tmo(int'(n == 40));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h35dc772a));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i));
      chk("reset value", rd_v, 32'h1);
    end
    rd(8'h30);
    chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
    wr(8'h30, 32'h0);
    chk("unmapped wr resp", 32'(rr), 32'(RESP_SLVERR));
    s = 4'($urandom_range(3));
    wr(OFS_STOP, 32'(s));
    chk("stop mode", 32'(smode), 32'(s));
    wr(OFS_UNIT, 32'h0);
    wr(OFS_COUNT, 32'h3);
    wr(OFS_IRQ_MASK, 32'hf);
    for (int i = 0; i < 3; i++) begin
      refs[i] = 16'($urandom_range(32'h7fff, 1));
      wr(8'h40 + 8'(4 * i), {14'h0, 2'(i), refs[i]});
      wr(8'h80 + 8'(4 * i), (i == 1) ? 32'h0 : 32'h14);
    end
    wr(OFS_MODE, 32'(MODE_INDIV));
    en <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("first ref", 32'(sref), 32'(refs[0]));
    chk("first group", 32'(grp), 32'h0);
    dir <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("inverted ref", 32'(sref), 32'(neg(refs[0])));
    dir <= 1'b0;
    fb <= refs[0];
    repeat (4) @(posedge core_clk);
    chk("reach", 32'(reach), 32'h1);
    for (n = 0; n < 100 && idx === 4'h0; n++) @(posedge core_clk);
    chk("run time", 32'(n >= 69 && n <= 75), 32'h1);
    repeat (6) @(posedge core_clk);
    chk("skip zero entry", 32'(idx), 32'h2);
    for (n = 0; n < 120 && run; n++) @(posedge core_clk);
    tmo(int'(n == 120));
    repeat (2) @(posedge core_clk);
    chk("done ref", 32'(sref), 32'h0);
    rd(OFS_IRQ_STAT);
    chk("done flag", 32'(rd_v[IRQ_DONE]), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    @(posedge core_clk);
    chk("masked irq", 32'(irq), 32'h0);
    wr(OFS_IRQ_STAT, 32'hf);
    rd(OFS_IRQ_STAT);
    chk("cleared status", rd_v, 32'h0);
    en <= 1'b0;
    wr(8'h80, 32'h2);
    wr(8'h88, 32'h2);
    wr(OFS_MODE, 32'(MODE_CYCLIC));
    en <= 1'b1;
    for (n = 0; n < 100 && idx !== 4'h2; n++) @(posedge core_clk);
    tmo(int'(n == 100));
    for (n = 0; n < 100 && idx !== 4'h0; n++) @(posedge core_clk);
    chk("wrap to first", 32'(n < 100), 32'h1);
    en <= 1'b0;
    for (n = 0; n < 5 && !stop; n++) @(posedge core_clk);
    chk("stop pulse", 32'(stop), 32'h1);
    s = 4'($urandom_range(2, 1));
    sel <= s;
    wr(OFS_MODE, 32'(MODE_DI));
    en <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("selected speed", 32'(idx), 32'(s));
    rd(OFS_STATUS);
    chk("status word", 32'(rd_v[7:0]), {24'h0, 1'b1, 3'h3, s});
    sel <= s ^ 4'h3;
    repeat (6) @(posedge core_clk);
    chk("reselected speed", 32'(idx), 32'(s ^ 4'h3));
    wr(OFS_MODE, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("undefined mode run", 32'(run), 32'h0);
    en <= 1'b0;
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule
